// [hw/ippm_defs.svh]
// constants for the interrupt priority and power mode block
//
// Overview of operation
// - global enable bit gates every source
// - external request 0: rank 1, vector 03h
// - serial receive valid: rank 2, vector 2Bh
// - timer 0 overflow: rank 3, vector 0Bh
// - serial receive error: rank 4, vector 33h
// - DMA channel 0 done: rank 5, vector 3Bh
// - external request 1: rank 6, vector 13h
// - serial transmit valid: rank 7, vector 43h
// - DMA channel 1 done: rank 8, vector 53h
// - timer 1 overflow: rank 9, vector 1Bh
// - serial transmit error: rank 10, own bits
// - async port: rank 11, lowest, vector 23h
// - two power states, chosen by software
// - idle bit write enters idle
// - idle stops execution and both DMA channels
// - serial channel keeps running while idle
// - enabled interrupt or reset leaves idle
// - power-down bit write enters power-down
// - power-down stops oscillator, RAM kept
// - only reset leaves power-down
// - idle: strobes high, port 0 floats, address out
// - power-down: strobes low, port 0 floats, data
// - enable register at A8h, resets cleared
`ifndef IPPM_DEFS_SVH
`define IPPM_DEFS_SVH

// special-function register addresses
`define IPPM_ADDR_IE 8'hA8
`define IPPM_ADDR_IEN1 8'hC8
`define IPPM_ADDR_IP 8'hB8
`define IPPM_ADDR_IPN1 8'hF8
`define IPPM_ADDR_POWER_CONTROL_REG 8'h87
`define IPPM_ADDR_GLOBAL_EN 8'hAF

// implemented bits of each register
`define IPPM_MASK_IE 8'h9F
`define IPPM_MASK_IEN1 8'h3F
`define IPPM_MASK_IP 8'h1F
`define IPPM_MASK_IPN1 8'h3F
`define IPPM_MASK_POWER_CONTROL_REG 8'h8F

// reset values
`define IPPM_RST_IE 8'h00
`define IPPM_RST_IEN1 8'h00
`define IPPM_RST_IP 8'h00
`define IPPM_RST_IPN1 8'h00
`define IPPM_RST_POWER_CONTROL_REG 8'h00

// field positions
`define IPPM_BIT_GLOBAL_EN 7
`define IPPM_BIT_IDLE 0
`define IPPM_BIT_PDOWN 1
`define IPPM_BIT_EXT0 0
`define IPPM_BIT_TIMER0 1
`define IPPM_BIT_EXT1 2
`define IPPM_BIT_TIMER1 3
`define IPPM_BIT_ASYNC 4
`define IPPM_BIT_RX_VALID 0
`define IPPM_BIT_RX_ERR 1
`define IPPM_BIT_DMA0 2
`define IPPM_BIT_TX_VALID 3
`define IPPM_BIT_DMA1 4
`define IPPM_BIT_TX_ERR 5

// source count and code vectors in rank order
`define IPPM_NUM_SRC 11
`define IPPM_VEC_EXT0 8'h03
`define IPPM_VEC_RX_VALID 8'h2B
`define IPPM_VEC_TIMER0 8'h0B
`define IPPM_VEC_RX_ERR 8'h33
`define IPPM_VEC_DMA0 8'h3B
`define IPPM_VEC_EXT1 8'h13
`define IPPM_VEC_TX_VALID 8'h43
`define IPPM_VEC_DMA1 8'h53
`define IPPM_VEC_TIMER1 8'h1B
`define IPPM_VEC_TX_ERR 8'h4B
`define IPPM_VEC_ASYNC 8'h23

`endif

// [hw/ippm_pkg.sv]
// types for the interrupt priority and power mode block
package ippm_pkg;

  typedef logic [3:0] ippm_rank_t;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN
  } ippm_mode_t;

  typedef struct packed {
    ippm_mode_t mode;
    logic [7:0] ie;
    logic [7:0] ien1;
    logic [7:0] ip;
    logic [7:0] ipn1;
    logic [7:0] power_control_reg;
    logic [1:0] ext_meta;
    logic [1:0] ext_sync;
    logic svc_hi;
    logic svc_lo;
    logic irq_req;
    logic [7:0] irq_vector;
    ippm_rank_t irq_rank;
    logic irq_high;
    logic cpu_run;
    logic dma_run;
    logic serial_run;
    logic osc_run;
    logic ram_retain;
    logic pin_override;
    logic ale_level;
    logic program_store_strobe_level;
    logic port0_oe;
    logic port2_addr_sel;
  } ippm_state_t;

endpackage

// [hw/ippm_arbiter.sv]
// fixed-rank arbiter over high and low priority request sets
`timescale 1ns/100ps
`include "ippm_defs.svh"
module ippm_arbiter (
  // requests by rank, bit 0 is rank 1
  input wire logic [`IPPM_NUM_SRC-1:0] req_hi,
  input wire logic [`IPPM_NUM_SRC-1:0] req_lo,
  // winner
  output logic valid,
  output ippm_pkg::ippm_rank_t idx,
  output logic high
);
  import ippm_pkg::*;

  // index of the lowest set bit, lowest index wins
  function automatic ippm_rank_t first_set(input logic [`IPPM_NUM_SRC-1:0] v);
    ippm_rank_t r;
    r = 4'h0;
    for (int i = `IPPM_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // high set pre-empts low set, rank decides inside a set
  always_comb begin
    valid = |req_hi || |req_lo;
    high = |req_hi;
    idx = high ? first_set(req_hi) : first_set(req_lo);
  end
endmodule // ippm_arbiter

// [hw/ippm_top.sv]
// interrupt arbitration and idle / power-down control
`timescale 1ns/100ps
`include "ippm_defs.svh"
module ippm_top (
  // clock and synchronous reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // byte write port for special-function registers
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  // bit write port for bit-addressable registers
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wdata,
  // register contents seen by the core
  output logic [7:0] ie_value,
  output logic [7:0] ien1_value,
  output logic [7:0] ip_value,
  output logic [7:0] ipn1_value,
  output logic [7:0] power_control_reg_value,
  // external request pins, active low levels
  input wire logic ext_req0_n,
  input wire logic ext_req1_n,
  // on-chip request levels, same clock
  input wire logic serial_rx_valid_req,
  input wire logic timer0_ovf_req,
  input wire logic serial_rx_err_req,
  input wire logic dma_ch0_done_req,
  input wire logic serial_tx_valid_req,
  input wire logic dma_ch1_done_req,
  input wire logic timer1_ovf_req,
  input wire logic serial_tx_err_req,
  input wire logic async_port_req,
  // vector handshake with the core
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output ippm_pkg::ippm_rank_t irq_rank,
  output logic irq_high,
  // power state
  output logic cpu_run,
  output logic dma_run,
  output logic serial_run,
  output logic osc_run,
  output logic ram_retain,
  output logic in_idle,
  output logic in_power_down,
  // pin levels while a power state holds the bus
  output logic pin_override,
  output logic ale_level,
  output logic program_store_strobe_level,
  output logic port0_oe,
  output logic port2_addr_sel
);
  import ippm_pkg::*;

  ippm_state_t s;
  ippm_state_t next_s;

  logic [`IPPM_NUM_SRC-1:0] pending;
  logic [`IPPM_NUM_SRC-1:0] src_en;
  logic [`IPPM_NUM_SRC-1:0] src_prio;
  logic [`IPPM_NUM_SRC-1:0] active;
  logic arb_valid;
  ippm_rank_t arb_idx;
  logic arb_high;
  logic post_ok;
  logic power_control_reg_written;

  // byte and bit writes merged into one register image
  function automatic logic [7:0] reg_write(input logic [7:0] old,
                                           input logic [7:0] base,
                                           input logic [7:0] mask);
    logic [7:0] v;
    v = old;
    if (sfr_wr && sfr_addr == base) begin
      v = sfr_wdata;
    end
    if (bit_wr && {bit_addr[7:3], 3'h0} == base) begin
      v[bit_addr[2:0]] = bit_wdata;
    end
    return v & mask;
  endfunction

  // code address of each source by rank
  function automatic logic [7:0] vector_of(input ippm_rank_t r);
    logic [7:0] v;
    v = `IPPM_VEC_EXT0;
    unique case (r)
      4'h0: v = `IPPM_VEC_EXT0;
      4'h1: v = `IPPM_VEC_RX_VALID;
      4'h2: v = `IPPM_VEC_TIMER0;
      4'h3: v = `IPPM_VEC_RX_ERR;
      4'h4: v = `IPPM_VEC_DMA0;
      4'h5: v = `IPPM_VEC_EXT1;
      4'h6: v = `IPPM_VEC_TX_VALID;
      4'h7: v = `IPPM_VEC_DMA1;
      4'h8: v = `IPPM_VEC_TIMER1;
      4'h9: v = `IPPM_VEC_TX_ERR;
      4'hA: v = `IPPM_VEC_ASYNC;
      default: v = `IPPM_VEC_EXT0;
    endcase
    return v;
  endfunction

  // request levels in rank order, pins after their synchroniser
  assign pending = {
    async_port_req,
    serial_tx_err_req,
    timer1_ovf_req,
    dma_ch1_done_req,
    serial_tx_valid_req,
    s.ext_sync[1],
    dma_ch0_done_req,
    serial_rx_err_req,
    timer0_ovf_req,
    serial_rx_valid_req,
    s.ext_sync[0]
  };

  // enable bit of each source in rank order
  assign src_en = {
    s.ie[`IPPM_BIT_ASYNC],
    s.ien1[`IPPM_BIT_TX_ERR],
    s.ie[`IPPM_BIT_TIMER1],
    s.ien1[`IPPM_BIT_DMA1],
    s.ien1[`IPPM_BIT_TX_VALID],
    s.ie[`IPPM_BIT_EXT1],
    s.ien1[`IPPM_BIT_DMA0],
    s.ien1[`IPPM_BIT_RX_ERR],
    s.ie[`IPPM_BIT_TIMER0],
    s.ien1[`IPPM_BIT_RX_VALID],
    s.ie[`IPPM_BIT_EXT0]
  };

  // priority bit of each source in rank order
  assign src_prio = {
    s.ip[`IPPM_BIT_ASYNC],
    s.ipn1[`IPPM_BIT_TX_ERR],
    s.ip[`IPPM_BIT_TIMER1],
    s.ipn1[`IPPM_BIT_DMA1],
    s.ipn1[`IPPM_BIT_TX_VALID],
    s.ip[`IPPM_BIT_EXT1],
    s.ipn1[`IPPM_BIT_DMA0],
    s.ipn1[`IPPM_BIT_RX_ERR],
    s.ip[`IPPM_BIT_TIMER0],
    s.ipn1[`IPPM_BIT_RX_VALID],
    s.ip[`IPPM_BIT_EXT0]
  };

  // global enable gates every source
  assign active = pending & src_en & {`IPPM_NUM_SRC{s.ie[`IPPM_BIT_GLOBAL_EN]}};

  // split by priority setting and pick the winner
  ippm_arbiter u_arbiter (
    .req_hi(active & src_prio),
    .req_lo(active & ~src_prio),
    .valid(arb_valid),
    .idx(arb_idx),
    .high(arb_high)
  );

  // a high request may pre-empt a low service, nothing pre-empts high
  assign post_ok = arb_valid && (arb_high ? !s.svc_hi : !(s.svc_hi || s.svc_lo));

  assign power_control_reg_written = sfr_wr && sfr_addr == `IPPM_ADDR_POWER_CONTROL_REG;

  // next state of the whole block
  always_comb begin
    next_s = s;
    if (s.mode == MODE_PDOWN) begin
      // oscillator stopped: nothing moves until reset
      next_s = s;
    end else begin
      // pin synchronisers, first stage read only by the second
      next_s.ext_meta = {!ext_req1_n, !ext_req0_n};
      next_s.ext_sync = s.ext_meta;

      // register writes from the core
      next_s.ie = reg_write(s.ie, `IPPM_ADDR_IE, `IPPM_MASK_IE);
      next_s.ien1 = reg_write(s.ien1, `IPPM_ADDR_IEN1, `IPPM_MASK_IEN1);
      next_s.ip = reg_write(s.ip, `IPPM_ADDR_IP, `IPPM_MASK_IP);
      next_s.ipn1 = reg_write(s.ipn1, `IPPM_ADDR_IPN1, `IPPM_MASK_IPN1);
      next_s.power_control_reg = reg_write(s.power_control_reg, `IPPM_ADDR_POWER_CONTROL_REG, `IPPM_MASK_POWER_CONTROL_REG);

      // power state changes
      unique case (s.mode)
        MODE_RUN: begin
          if (power_control_reg_written && sfr_wdata[`IPPM_BIT_PDOWN]) begin
            next_s.mode = MODE_PDOWN;
          end else if (power_control_reg_written && sfr_wdata[`IPPM_BIT_IDLE]) begin
            next_s.mode = MODE_IDLE;
          end
        end
        MODE_IDLE: begin
          if (|active) begin
            next_s.mode = MODE_RUN;
            next_s.power_control_reg[`IPPM_BIT_IDLE] = 1'b0;
          end
        end
        MODE_PDOWN: begin
          next_s.mode = MODE_PDOWN;
        end
      endcase

      // in-service tracking, acknowledge before return
      if (irq_ack && s.irq_req) begin
        if (s.irq_high) begin
          next_s.svc_hi = 1'b1;
        end else begin
          next_s.svc_lo = 1'b1;
        end
      end else if (irq_return) begin
        if (s.svc_hi) begin
          next_s.svc_hi = 1'b0;
        end else begin
          next_s.svc_lo = 1'b0;
        end
      end

      // request to the core, only while it executes
      next_s.irq_req = 1'b0;
      if (s.mode == MODE_RUN && !(irq_ack && s.irq_req) && post_ok) begin
        next_s.irq_req = 1'b1;
        next_s.irq_rank = ippm_rank_t'(arb_idx + 4'h1); // rank counts from 1
        next_s.irq_high = arb_high;
        next_s.irq_vector = vector_of(arb_idx);
      end
    end

    // run enables and pin levels follow the next mode
    next_s.cpu_run = next_s.mode == MODE_RUN;
    next_s.dma_run = next_s.mode == MODE_RUN;
    next_s.serial_run = next_s.mode != MODE_PDOWN;
    next_s.osc_run = next_s.mode != MODE_PDOWN;
    next_s.ram_retain = 1'b1;
    next_s.pin_override = next_s.mode != MODE_RUN;
    next_s.ale_level = next_s.mode != MODE_PDOWN;
    next_s.program_store_strobe_level = next_s.mode != MODE_PDOWN;
    next_s.port0_oe = next_s.mode == MODE_RUN;
    next_s.port2_addr_sel = next_s.mode != MODE_PDOWN;
    if (next_s.mode != MODE_RUN) begin
      next_s.irq_req = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s.mode <= MODE_RUN;
      s.ie <= `IPPM_RST_IE;
      s.ien1 <= `IPPM_RST_IEN1;
      s.ip <= `IPPM_RST_IP;
      s.ipn1 <= `IPPM_RST_IPN1;
      s.power_control_reg <= `IPPM_RST_POWER_CONTROL_REG;
      s.ext_meta <= 2'h0;
      s.ext_sync <= 2'h0;
      s.svc_hi <= 1'b0;
      s.svc_lo <= 1'b0;
      s.irq_req <= 1'b0;
      s.irq_vector <= 8'h00;
      s.irq_rank <= 4'h0;
      s.irq_high <= 1'b0;
      s.cpu_run <= 1'b1;
      s.dma_run <= 1'b1;
      s.serial_run <= 1'b1;
      s.osc_run <= 1'b1;
      s.ram_retain <= 1'b1;
      s.pin_override <= 1'b0;
      s.ale_level <= 1'b1;
      s.program_store_strobe_level <= 1'b1;
      s.port0_oe <= 1'b1;
      s.port2_addr_sel <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign ie_value = s.ie;
  assign ien1_value = s.ien1;
  assign ip_value = s.ip;
  assign ipn1_value = s.ipn1;
  assign power_control_reg_value = s.power_control_reg;
  assign irq_req = s.irq_req;
  assign irq_vector = s.irq_vector;
  assign irq_rank = s.irq_rank;
  assign irq_high = s.irq_high;
  assign cpu_run = s.cpu_run;
  assign dma_run = s.dma_run;
  assign serial_run = s.serial_run;
  assign osc_run = s.osc_run;
  assign ram_retain = s.ram_retain;
  assign in_idle = s.mode == MODE_IDLE;
  assign in_power_down = s.mode == MODE_PDOWN;
  assign pin_override = s.pin_override;
  assign ale_level = s.ale_level;
  assign program_store_strobe_level = s.program_store_strobe_level;
  assign port0_oe = s.port0_oe;
  assign port2_addr_sel = s.port2_addr_sel;
endmodule // ippm_top

// [test/ippm_checker.sv]
// assertion checker for the interrupt and power mode block
`timescale 1ns/100ps
module ippm_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register writes
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] ie_value,
  // vector handshake
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire ippm_pkg::ippm_rank_t irq_rank,
  // power state and pins
  input wire logic cpu_run,
  input wire logic dma_run,
  input wire logic serial_run,
  input wire logic osc_run,
  input wire logic ram_retain,
  input wire logic in_idle,
  input wire logic in_power_down,
  input wire logic pin_override,
  input wire logic ale_level,
  input wire logic program_store_strobe_level,
  input wire logic port0_oe,
  input wire logic port2_addr_sel
);
  import ippm_pkg::*;
  localparam logic [7:0] VEC [1:11] = '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43,
    8'h53, 8'h1B, 8'h4B, 8'h23};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // power-control byte write taken while running
  sequence s_power_control_reg_wr(d);
    sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1:0] == d && !in_idle && !in_power_down;
  endsequence
  a_global_gate: assert property (!ie_value[7] ##1 !ie_value[7] |-> !irq_req)
    else $error("request posted with global enable clear");
  a_vector_map: assert property (irq_req |-> irq_rank inside {[4'h1:4'hB]}
    && irq_vector == VEC[irq_rank]) else $error("vector does not match rank");
  a_ack_drop: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request kept after acknowledge");
  a_idle_enter: assert property (s_power_control_reg_wr(2'h1) |=> in_idle)
    else $error("idle not entered");
  a_pdown_enter: assert property (s_power_control_reg_wr(2'h2) |=> in_power_down)
    else $error("power-down not entered");
  a_pdown_hold: assert property (in_power_down |=> in_power_down)
    else $error("power-down left without reset");
  a_pdown_pins: assert property (in_power_down |-> !cpu_run && !osc_run && ram_retain
    && !ale_level && !program_store_strobe_level && !port0_oe && !port2_addr_sel) else $error("power-down pins");
  a_idle_pins: assert property (in_idle |-> !cpu_run && !dma_run && serial_run
    && ale_level && program_store_strobe_level && !port0_oe && port2_addr_sel && pin_override)
    else $error("idle state outputs");
  a_run_state: assert property (!in_idle && !in_power_down |-> cpu_run && dma_run
    && osc_run && port0_oe && !pin_override) else $error("run state outputs");
endmodule // ippm_checker

bind ippm_top ippm_checker u_ippm_checker (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .ie_value(ie_value), .irq_ack(irq_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_rank(irq_rank), .cpu_run(cpu_run),
  .dma_run(dma_run), .serial_run(serial_run), .osc_run(osc_run), .ram_retain(ram_retain),
  .in_idle(in_idle), .in_power_down(in_power_down), .pin_override(pin_override),
  .ale_level(ale_level), .program_store_strobe_level(program_store_strobe_level), .port0_oe(port0_oe),
  .port2_addr_sel(port2_addr_sel));

// [test/ippm_core_model.sv]
// processor core model that takes posted vectors and ends service
`timescale 1ns/100ps
module ippm_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bench control
  input wire logic ack_en,
  // handshake with the block
  input wire logic irq_req,
  input wire logic cpu_run,
  output logic irq_ack,
  output logic irq_return,
  output int ack_total
);
  logic [1:0] wait_cnt;
  logic [2:0] svc_cnt;
  // take a vector after a short wait, end its service four cycles later
  always @(posedge clk_sys) begin
    irq_ack <= 1'b0;
    irq_return <= 1'b0;
    if (!rst_n) begin
      wait_cnt <= 2'h0;
      svc_cnt <= 3'h0;
      ack_total <= 0;
    end else if (svc_cnt != 3'h0) begin
      svc_cnt <= svc_cnt - 3'h1;
      irq_return <= (svc_cnt == 3'h1);
    end else if (ack_en && irq_req && cpu_run) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h2) begin
        irq_ack <= 1'b1;
        svc_cnt <= 3'h4;
        ack_total <= ack_total + 1;
      end
    end else begin
      wait_cnt <= 2'h0;
    end
  end
endmodule // ippm_core_model

// [test/ippm_top_tb_top.sv]
// self-checking bench for the interrupt and power mode block
`timescale 1ns/100ps
module ippm_top_tb_top;
  import ippm_pkg::*;
  localparam logic [7:0] VEC [11] = '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43, 8'h53,
    8'h1B, 8'h4B, 8'h23};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic bit_wr = 1'b0;
  logic [7:0] bit_addr = 8'h00;
  logic bit_wdata = 1'b0;
  logic [10:0] src = 11'h000;
  logic ack_en = 1'b0;
  logic [7:0] ie_value, ien1_value, ip_value, ipn1_value, power_control_reg_value, irq_vector;
  ippm_rank_t irq_rank;
  logic irq_ack, irq_return, irq_req, irq_high, cpu_run, dma_run, serial_run, osc_run;
  logic ram_retain, in_idle, in_power_down, pin_override, ale_level, program_store_strobe_level;
  logic port0_oe, port2_addr_sel;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int ack_total;

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  ippm_top u_ippm_top (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .ie_value(ie_value), .ien1_value(ien1_value), .ip_value(ip_value), .ipn1_value(ipn1_value),
    .power_control_reg_value(power_control_reg_value), .ext_req0_n(~src[0]), .ext_req1_n(~src[5]),
    .serial_rx_valid_req(src[1]), .timer0_ovf_req(src[2]), .serial_rx_err_req(src[3]),
    .dma_ch0_done_req(src[4]), .serial_tx_valid_req(src[6]), .dma_ch1_done_req(src[7]),
    .timer1_ovf_req(src[8]), .serial_tx_err_req(src[9]), .async_port_req(src[10]),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_rank(irq_rank), .irq_high(irq_high), .cpu_run(cpu_run), .dma_run(dma_run),
    .serial_run(serial_run), .osc_run(osc_run), .ram_retain(ram_retain), .in_idle(in_idle),
    .in_power_down(in_power_down), .pin_override(pin_override), .ale_level(ale_level),
    .program_store_strobe_level(program_store_strobe_level), .port0_oe(port0_oe), .port2_addr_sel(port2_addr_sel));

  ippm_core_model u_ippm_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .ack_en(ack_en),
    .irq_req(irq_req), .cpu_run(cpu_run), .irq_ack(irq_ack), .irq_return(irq_return),
    .ack_total(ack_total));

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic cmpv(input string name, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic got);
    cmpv(name, {39'h0, exp}, {39'h0, got});
  endtask

  // byte write, then one cycle for the register to show it
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask

  task automatic bit_write(input logic [7:0] a, input logic d);
    tick(1);
    bit_wr = 1'b1;
    bit_addr = a;
    bit_wdata = d;
    tick(1);
    bit_wr = 1'b0;
    tick(1);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    tick(1);
    do_reset();
    cmpv("regs", 40'h0, {ie_value, ien1_value, ip_value, ipn1_value, power_control_reg_value});
    sfr_write(8'hA8, 8'hFF);
    cmpv("ie", 40'h9F, ie_value);
    sfr_write(8'hC8, 8'hFF);
    sfr_write(8'h55, 8'hFF);
    cmpv("ien1", 40'h3F, ien1_value);
    bit_write(8'hAF, 1'b0);
    cmpv("ie", 40'h1F, ie_value);
    src = 11'h7FF;
    tick(5);
    cmp1("irq_req", 1'b0, irq_req);
    bit_write(8'hAF, 1'b1);
    // lowest pending rank wins, each with its own vector
    for (int i = 10; i >= 0; i--) begin
      src = 11'h7FF << i;
      tick(5);
      cmp1("irq_req", 1'b1, irq_req);
      cmpv("rank", 40'(i + 1), irq_rank);
      cmpv("vector", 40'(VEC[i]), irq_vector);
    end
    bit_write(8'hA8, 1'b0);
    tick(4);
    cmpv("rank", 40'h2, irq_rank);
    bit_write(8'hC8, 1'b0);
    tick(4);
    cmpv("rank", 40'h3, irq_rank);
    // priority bits pre-empt fixed rank
    sfr_write(8'hB8, 8'hF0);
    cmpv("ip", 40'h10, ip_value);
    tick(2);
    cmpv("rank", 40'hB, irq_rank);
    cmp1("irq_high", 1'b1, irq_high);
    sfr_write(8'hF8, 8'hE0);
    tick(2);
    cmpv("rank", 40'hA, irq_rank);
    sfr_write(8'hB8, 8'h00);
    sfr_write(8'hF8, 8'h00);
    // core takes the vector, request falls
    src = 11'h004;
    ack_en = 1'b1;
    for (int k = 0; k < 20 && irq_ack !== 1'b1; k++) tick(1);
    tick(1);
    cmp1("irq_req", 1'b0, irq_req);
    cmpv("acks", 40'h1, 40'(ack_total));
    ack_en = 1'b0;
    src = 11'h000;
    tick(8);
    // idle, a disabled request does not wake it, an enabled one does
    sfr_write(8'h87, 8'h01);
    cmp1("in_idle", 1'b1, in_idle);
    cmpv("idle_run", 40'h3, {cpu_run, dma_run, serial_run, osc_run});
    cmpv("idle_pins", 40'h1D, {pin_override, ale_level, program_store_strobe_level, port0_oe, port2_addr_sel});
    src = 11'h001;
    tick(5);
    cmp1("in_idle", 1'b1, in_idle);
    src = 11'h004;
    tick(2);
    cmp1("in_idle", 1'b0, in_idle);
    cmpv("power_control_reg", 40'h0, power_control_reg_value);
    src = 11'h000;
    tick(8);
    // power-down holds against requests and writes
    sfr_write(8'h87, 8'h02);
    cmp1("in_power_down", 1'b1, in_power_down);
    cmpv("pd_run", 40'h1, {cpu_run, dma_run, serial_run, osc_run, ram_retain});
    cmpv("pd_pins", 40'h0, {ale_level, program_store_strobe_level, port0_oe, port2_addr_sel});
    src = 11'h7FF;
    sfr_write(8'hA8, 8'h00);
    tick(5);
    cmp1("in_power_down", 1'b1, in_power_down);
    cmpv("ie", 40'h9E, ie_value);
    do_reset();
    tick(1);
    cmp1("in_power_down", 1'b0, in_power_down);
    cmpv("regs", 40'h0, {ie_value, ien1_value, ip_value, ipn1_value, power_control_reg_value});
    final_report();
  end
endmodule // ippm_top_tb_top
